// ==== asio_divider.sv ====
// Signed restoring divider for the analog scaling path
`timescale 1ns/1ps
`default_nettype none
module asio_divider
  import asio_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        start,
  input  wire logic [31:0] dividend,
  input  wire logic [31:0] divisor,
  output logic             done,
  output logic [31:0]      quotient
);

  typedef enum logic [1:0] {
    DV_IDLE = 2'b01,
    DV_RUN  = 2'b10
  } asio_dv_state_t;

  typedef struct packed {
    asio_dv_state_t st;
    logic [5:0]     cnt;
    logic [31:0]    rem;
    logic [31:0]    quo;
    logic [31:0]    den;
    logic           neg;
    logic           done;
    logic [31:0]    result;
  } asio_dv_t;

  asio_dv_t r;
  asio_dv_t next_r;
  logic [32:0] trial;

  // Magnitude division, sign applied last so the quotient truncates toward zero
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    trial = 33'h0_0000_0000;
    unique case (r.st)
      DV_IDLE: begin
        if (start) begin
          next_r.st  = DV_RUN;
          next_r.cnt = 6'(DIV_STEPS);
          next_r.rem = 32'h0000_0000;
          next_r.quo = dividend[31] ? 32'(-dividend) : dividend;
          next_r.den = divisor[31] ? 32'(-divisor) : divisor;
          next_r.neg = dividend[31] ^ divisor[31];
        end
      end
      DV_RUN: begin
        trial = {r.rem, r.quo[31]} - {1'b0, r.den};
        if (!trial[32]) begin
          next_r.rem = trial[31:0];
          next_r.quo = {r.quo[30:0], 1'b1};
        end else begin
          next_r.rem = {r.rem[30:0], r.quo[31]};
          next_r.quo = {r.quo[30:0], 1'b0};
        end
        next_r.cnt = r.cnt - 6'h01;
        if (r.cnt == 6'h01) begin
          next_r.st     = DV_IDLE;
          next_r.done   = 1'b1;
          next_r.result = r.neg ? 32'(-next_r.quo) : next_r.quo;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{st: DV_IDLE, cnt: 6'h00, rem: 32'h0, quo: 32'h0, den: 32'h0,
             neg: 1'b0, done: 1'b0, result: 32'h0};
    end else begin
      r <= next_r;
    end
  end

  assign done     = r.done;
  assign quotient = r.result;

  // Done is sampled high one clock after the last of the DIV_STEPS steps
  a_div_latency : assert property (@(posedge sys_clk) disable iff (!arst_n)
    (start && r.st == DV_IDLE) |-> ##33 done) else $error("divider latency wrong");

endmodule : asio_divider
`default_nettype wire

// ==== asio_master_model.sv ====
// Behavioural fieldbus master that issues object accesses to the bank
`timescale 1ns/1ps
`default_nettype none
module asio_master_model
  import asio_pkg::*;
(
  input  wire logic  sys_clk,
  output var asio_req_t req
);
  initial req = '0;

  // One access per call; consecutive calls give back-to-back requests
  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] wd, input logic zero_ok);
    @(negedge sys_clk);
    // A real master never sends a zero divisor unless told to misbehave
    if (wr && idx == IDX_DIVISOR && wd == ZERO_WORD && !zero_ok)
      req = {1'b1, wr, idx, sub, DIVISOR_PRESET};
    else
      req = {1'b1, wr, idx, sub, wd};
    @(posedge sys_clk);
  endtask

  // Idle bus shows inverted leftovers so no stale value can pass for a match
  task automatic release_bus();
    @(negedge sys_clk);
    req = {1'b0, ~req[$bits(asio_req_t)-2:0]};
  endtask
endmodule // asio_master_model
`default_nettype wire

// ==== asio_object_bank.sv ====
// Object bank: analog scaling, following error reaction and hardware information
`timescale 1ns/1ps
`default_nettype none
module asio_object_bank
  import asio_pkg::*;
#(
  parameter int          STR_BYTES    = 4,
  parameter logic [31:0] EEPROM_BYTES = 32'h0000_0000
) (
  input  wire logic            sys_clk,
  input  wire logic            arst_n,
  input  wire asio_req_t       req,
  output asio_rsp_t            rsp,
  input  wire logic            raw_valid,
  input  wire logic [31:0]     raw_in1,
  input  wire logic [31:0]     raw_in2,
  input  wire logic [31:0]     power_supply_voltage_mv,
  input  wire logic [31:0]     logic_supply_voltage_mv,
  input  wire logic [31:0]     board_temp_dc,
  input  wire logic [8*STR_BYTES-1:0] serial_number,
  input  wire logic [8*STR_BYTES-1:0] device_id,
  input  wire logic            following_error,
  output logic [31:0]          scaled_in1,
  output logic [31:0]          scaled_in2,
  output logic [31:0]          hw_config,
  output asio_fe_action_t      fe_action
);

  // Strings come back in one 32-bit answer, so longer ones cannot be served
  if (STR_BYTES < 1 || STR_BYTES > 4) begin : g_bad_str_bytes
    $error("STR_BYTES must be 1 to 4");
  end

  typedef enum logic [2:0] {
    SC_IDLE = 3'b001,
    SC_IN1  = 3'b010,
    SC_IN2  = 3'b100
  } asio_sc_state_t;

  typedef struct packed {
    logic [1:0][31:0] offset;
    logic [1:0][31:0] divisor;
    logic [15:0]      fe_code;
    logic [31:0]      hw_config;
    asio_rsp_t        rsp;
    asio_sc_state_t   sc;
    logic [1:0][31:0] scaled;
    logic [1:0][31:0] sample;
    logic             pend;
    asio_fe_action_t  fe_action;
  } asio_st_t;

  // Two flops on the supply, logic and temperature readings and the following error before any logic looks at them
  logic [31:0] supply_meta;
  logic [31:0] supply_sync;
  logic [31:0] logic_meta;
  logic [31:0] logic_sync;
  logic [31:0] temp_meta;
  logic [31:0] temp_sync;
  logic        fe_meta;
  logic        fe_sync;

  asio_st_t    r;
  asio_st_t    next_r;
  logic        div_start;
  logic [31:0] div_dividend;
  logic [31:0] div_divisor;
  logic        div_done;
  logic [31:0] div_quot;

  // Subindex is 1 or 2: a valid analog input slot
  function automatic logic in_slot(input logic [7:0] sub);
    return (sub == SUB_ONE) || (sub == SUB_TWO);
  endfunction

  // Map a reaction code onto the one-hot action
  function automatic asio_fe_action_t decode_fe(input logic [15:0] code);
    asio_fe_action_t a;
    a = '0;
    unique case (code)
      FE_NONE:      a.none       = 1'b1;
      FE_IMMEDIATE: a.immediate  = 1'b1;
      FE_SLOW_RAMP: a.slow_ramp  = 1'b1;
      FE_QUICK:     a.quick_ramp = 1'b1;
      default:      a.none       = 1'b1; // reserved codes do nothing
    endcase
    return a;
  endfunction

  // Input synchronisers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      supply_meta <= 32'h0000_0000;
      supply_sync <= 32'h0000_0000;
      logic_meta  <= 32'h0000_0000;
      logic_sync  <= 32'h0000_0000;
      temp_meta   <= 32'h0000_0000;
      temp_sync   <= 32'h0000_0000;
      fe_meta     <= 1'b0;
      fe_sync     <= 1'b0;
    end else begin
      supply_meta <= power_supply_voltage_mv;
      supply_sync <= supply_meta;
      logic_meta  <= logic_supply_voltage_mv;
      logic_sync  <= logic_meta;
      temp_meta   <= board_temp_dc;
      temp_sync   <= temp_meta;
      fe_meta     <= following_error;
      fe_sync     <= fe_meta;
    end
  end

  // Object access, scaling sequencer and reaction decode
  always_comb begin
    next_r = r;
    next_r.rsp = '0;
    div_start    = 1'b0;
    div_dividend = 32'h0000_0000;
    div_divisor  = DIVISOR_PRESET;

    if (req.valid) begin
      next_r.rsp.valid = 1'b1;
      unique case (req.index)
        IDX_OFFSET, IDX_DIVISOR: begin
          if (req.subindex == SUB_COUNT) begin
            if (req.write) next_r.rsp.abort_code = ABORT_READONLY;
            else next_r.rsp.rdata = NUM_ANALOG_IN;
          end else if (in_slot(req.subindex)) begin
            if (req.index == IDX_OFFSET) begin
              if (req.write) next_r.offset[req.subindex[1]] = req.wdata;
              else next_r.rsp.rdata = r.offset[req.subindex[1]];
            end else if (!req.write) begin
              next_r.rsp.rdata = r.divisor[req.subindex[1]];
            end else if (req.wdata == ZERO_WORD) begin
              next_r.rsp.abort_code = ABORT_RANGE;
            end else begin
              next_r.divisor[req.subindex[1]] = req.wdata;
            end
          end else next_r.rsp.abort_code = ABORT_NO_SUB;
        end
        IDX_FE_REACT: begin
          if (req.write) next_r.fe_code = req.wdata[15:0];
          else next_r.rsp.rdata = {{16{r.fe_code[15]}}, r.fe_code};
        end
        IDX_HW_INFO: begin
          if (req.write) next_r.rsp.abort_code = ABORT_READONLY;
          else if (req.subindex == SUB_COUNT) next_r.rsp.rdata = NUM_HW_INFO;
          else if (req.subindex == SUB_ONE) next_r.rsp.rdata = EEPROM_BYTES;
          else next_r.rsp.abort_code = ABORT_NO_SUB;
        end
        IDX_HW_CONFIG: begin
          if (req.subindex == SUB_COUNT) begin
            if (req.write) next_r.rsp.abort_code = ABORT_READONLY;
            else next_r.rsp.rdata = NUM_HW_CONFIG;
          end else if (req.subindex == SUB_ONE) begin
            if (req.write) next_r.hw_config = req.wdata & HW_CONFIG_MASK;
            else next_r.rsp.rdata = r.hw_config;
          end else next_r.rsp.abort_code = ABORT_NO_SUB;
        end
        IDX_OP_COND: begin
          if (req.write) next_r.rsp.abort_code = ABORT_READONLY;
          else if (req.subindex == SUB_COUNT) next_r.rsp.rdata = NUM_OP_COND;
          else if (req.subindex == SUB_ONE) next_r.rsp.rdata = supply_sync;
          else if (req.subindex == SUB_TWO) next_r.rsp.rdata = logic_sync;
          else if (req.subindex == SUB_THREE) next_r.rsp.rdata = temp_sync;
          else next_r.rsp.abort_code = ABORT_NO_SUB;
        end
        IDX_SERIAL, IDX_DEVICE_ID: begin
          // Strings are returned whole in one word, never stored
          if (req.write) next_r.rsp.abort_code = ABORT_READONLY;
          else if (req.index == IDX_SERIAL) next_r.rsp.rdata = 32'(serial_number);
          else next_r.rsp.rdata = 32'(device_id);
        end
        default: next_r.rsp.abort_code = ABORT_NO_OBJ;
      endcase
      next_r.rsp.abort = (next_r.rsp.abort_code != ABORT_NONE);
    end

    // A fresh sample waits here while the divider is busy; newest wins
    if (raw_valid) begin
      next_r.pend   = 1'b1;
      next_r.sample = {raw_in2, raw_in1};
    end

    unique case (r.sc)
      SC_IDLE: begin
        if (r.pend) begin
          next_r.pend  = raw_valid;
          next_r.sc    = SC_IN1;
          div_start    = 1'b1;
          div_dividend = 32'(r.sample[0] + r.offset[0]);
          div_divisor  = r.divisor[0];
        end
      end
      SC_IN1: begin
        if (div_done) begin
          next_r.scaled[0] = div_quot;
          next_r.sc        = SC_IN2;
          div_start        = 1'b1;
          div_dividend     = 32'(r.sample[1] + r.offset[1]);
          div_divisor      = r.divisor[1];
        end
      end
      SC_IN2: begin
        if (div_done) begin
          next_r.scaled[1] = div_quot;
          next_r.sc        = SC_IDLE;
        end
      end
    endcase

    // Action stands while the following error is asserted
    next_r.fe_action = fe_sync ? decode_fe(r.fe_code) : '0;
  end

  // State register; presets leave scaled value equal to raw counts
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{offset: {OFFSET_PRESET, OFFSET_PRESET}, divisor: {DIVISOR_PRESET, DIVISOR_PRESET},
             fe_code: FE_REACT_PRESET, hw_config: HW_CONFIG_PRESET, rsp: '0, sc: SC_IDLE,
             scaled: '0, sample: '0, pend: 1'b0, fe_action: '0};
    end else begin
      r <= next_r;
    end
  end

  asio_divider u_div (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .start    (div_start),
    .dividend (div_dividend),
    .divisor  (div_divisor),
    .done     (div_done),
    .quotient (div_quot)
  );

  assign rsp        = r.rsp;
  assign scaled_in1 = r.scaled[0];
  assign scaled_in2 = r.scaled[1];
  assign hw_config  = r.hw_config;
  assign fe_action  = r.fe_action;

  a_div_zero_kept : assert property (@(posedge sys_clk) disable iff (!arst_n)
    (req.valid && req.write && req.index == IDX_DIVISOR && in_slot(req.subindex) && req.wdata == 32'h0)
    |=> (rsp.abort && $stable(r.divisor))) else $error("zero divisor accepted");
  a_div_nonzero : assert property (@(posedge sys_clk) disable iff (!arst_n)
    r.divisor[0] != 32'h0 && r.divisor[1] != 32'h0) else $error("divisor became zero");
  a_count_two : assert property (@(posedge sys_clk) disable iff (!arst_n)
    (req.valid && !req.write && req.index == IDX_OFFSET && req.subindex == SUB_COUNT)
    |=> rsp.rdata == 32'h2) else $error("input count not two");
  a_cfg_bit0 : assert property (@(posedge sys_clk) disable iff (!arst_n)
    !hw_config[0]) else $error("reserved config bit set");
  a_ro_abort : assert property (@(posedge sys_clk) disable iff (!arst_n)
    (req.valid && req.write && (req.index == IDX_OP_COND || req.index == IDX_SERIAL || req.index == IDX_HW_INFO))
    |=> rsp.abort) else $error("read-only write accepted");
  a_eeprom_read : assert property (@(posedge sys_clk) disable iff (!arst_n)
    (req.valid && !req.write && req.index == IDX_HW_INFO && req.subindex == SUB_ONE)
    |=> rsp.rdata == EEPROM_BYTES) else $error("eeprom size wrong");
  a_fe_none : assert property (@(posedge sys_clk) disable iff (!arst_n)
    (fe_sync && r.fe_code == FE_NONE) |=> fe_action.none && !fe_action.immediate)
    else $error("reaction code misdecoded");
  a_supply_read : assert property (@(posedge sys_clk) disable iff (!arst_n)
    (req.valid && !req.write && req.index == IDX_OP_COND && req.subindex == SUB_ONE)
    |=> rsp.rdata == $past(supply_sync)) else $error("supply reading wrong");
  a_scale_unity : assert property (@(posedge sys_clk) disable iff (!arst_n)
    (r.sc == SC_IDLE && r.pend && r.offset[0] == 32'h0 && r.divisor[0] == 32'h1 && !req.valid)
    |-> ##34 scaled_in1 == $past(r.sample[0], 34)) else $error("unity scaling broken");

  c_div_write : cover property (@(posedge sys_clk) req.valid && req.write && req.index == IDX_DIVISOR);
  c_zero_abort : cover property (@(posedge sys_clk) rsp.abort && rsp.abort_code == ABORT_RANGE);
  c_scaled_done : cover property (@(posedge sys_clk) r.sc == SC_IN2 && div_done);
  c_fe_quick : cover property (@(posedge sys_clk) fe_action.quick_ramp);

endmodule : asio_object_bank
`default_nettype wire

// ==== asio_object_bank_bench.sv ====
// Self-checking bench for the analog scaling and information object bank
`timescale 1ns/1ps
`default_nettype none
module asio_object_bank_bench
  import asio_pkg::*;
;
  logic            sys_clk = 1'b0;
  logic            arst_n = 1'b0;
  asio_req_t       req;
  asio_rsp_t       rsp;
  logic            raw_valid = 1'b0;
  logic [31:0]     raw_in1 = 32'h0000_0000;
  logic [31:0]     raw_in2 = 32'h0000_0000;
  logic [31:0]     pwr, lgc, tmp, ser, did;
  logic            following_error = 1'b0;
  logic [31:0]     scaled_in1, scaled_in2, hw_config;
  asio_fe_action_t fe_action;
  logic [31:0]     seed = 32'h0001_8663;
  asio_rsp_t       exp_q[$];
  logic            chk_q[$];
  int              n_errors = 0;
  int              tests_run = 0;

  always #50 sys_clk = ~sys_clk;

  // Galois-free shift form; the seed is stepped on every draw
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  initial begin
    pwr = rnd();
    lgc = rnd();
    tmp = rnd();
    ser = rnd();
    did = rnd();
  end

  asio_master_model i_master (
    .sys_clk (sys_clk),
    .req     (req)
  );

  asio_object_bank #(.STR_BYTES(4), .EEPROM_BYTES(32'h0000_0000)) i_dut (
    .sys_clk                 (sys_clk),
    .arst_n                  (arst_n),
    .req                     (req),
    .rsp                     (rsp),
    .raw_valid               (raw_valid),
    .raw_in1                 (raw_in1),
    .raw_in2                 (raw_in2),
    .power_supply_voltage_mv (pwr),
    .logic_supply_voltage_mv (lgc),
    .board_temp_dc           (tmp),
    .serial_number           (ser),
    .device_id               (did),
    .following_error         (following_error),
    .scaled_in1              (scaled_in1),
    .scaled_in2              (scaled_in2),
    .hw_config               (hw_config),
    .fe_action               (fe_action)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
    tests_run++;
    if (seen !== expv) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, expv, seen);
    end
  endtask

  // Note the answer first, then let the master issue the access
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                     input logic [31:0] wd, input logic [31:0] code, input logic [31:0] rd,
                     input logic zero_ok = 1'b0);
    exp_q.push_back({1'b1, code != ABORT_NONE, code, rd});
    chk_q.push_back(!wr && code == ABORT_NONE);
    i_master.access(wr, idx, sub, wd, zero_ok);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] v);
    acc(1'b0, idx, sub, 32'h0000_0000, ABORT_NONE, v);
  endtask

  // Answer monitor: oldest note is matched against each answer
  always @(negedge sys_clk) begin
    asio_rsp_t e;
    logic      c;
    if (arst_n && rsp.valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected answer", 32'h0000_0001, 32'h0000_0000);
      end else begin
        e = exp_q.pop_front();
        c = chk_q.pop_front();
        check("abort flag", {31'h0, rsp.abort}, {31'h0, e.abort});
        check("abort code", rsp.abort_code, e.abort_code);
        if (c) check("read data", rsp.rdata, e.rdata);
      end
    end
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Whole run needs under a thousand cycles; 20000 is far beyond that and means a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    wrap_up();
  end

  logic [23:0] ro [12] = '{24'h3321_00, 24'h3322_00, 24'h4012_00, 24'h4012_01, 24'h4013_00, 24'h4014_00,
                           24'h4014_01, 24'h4014_02, 24'h4014_03, 24'h4040_00, 24'h4041_00, 24'h3321_00};
  logic [15:0] codes [5] = '{16'hFFFF, 16'h0000, 16'h0001, 16'h0002, 16'h0005};
  logic [3:0]  acts  [5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h8};

  initial begin
    logic signed [31:0] o1, o2, d1, d2, r1, r2, q;
    logic [31:0]        t;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    // Presets, counts and read-only information
    rd(IDX_OFFSET, SUB_COUNT, NUM_ANALOG_IN);
    rd(IDX_OFFSET, SUB_ONE, OFFSET_PRESET);
    rd(IDX_OFFSET, SUB_TWO, OFFSET_PRESET);
    rd(IDX_DIVISOR, SUB_COUNT, NUM_ANALOG_IN);
    rd(IDX_DIVISOR, SUB_ONE, DIVISOR_PRESET);
    rd(IDX_DIVISOR, SUB_TWO, DIVISOR_PRESET);
    rd(IDX_FE_REACT, SUB_COUNT, 32'hFFFF_FFFF);
    rd(IDX_HW_INFO, SUB_COUNT, 32'h0000_0001);
    rd(IDX_HW_INFO, SUB_ONE, 32'h0000_0000);
    rd(IDX_HW_CONFIG, SUB_COUNT, 32'h0000_0001);
    rd(IDX_HW_CONFIG, SUB_ONE, HW_CONFIG_PRESET);
    rd(IDX_OP_COND, SUB_COUNT, 32'h0000_0003);
    rd(IDX_OP_COND, SUB_ONE, pwr);
    rd(IDX_OP_COND, SUB_TWO, lgc);
    rd(IDX_OP_COND, SUB_THREE, tmp);
    rd(IDX_SERIAL, SUB_COUNT, ser);
    rd(IDX_DEVICE_ID, SUB_COUNT, did);
    i_master.release_bus();
    check("config port", hw_config, 32'h0000_0000);
    $display("test presets done");
    // Refusals, back to back; zero divisor must leave the old one
    foreach (ro[i]) acc(1'b1, ro[i][23:8], ro[i][7:0], rnd(), ABORT_READONLY, 32'h0);
    acc(1'b1, IDX_OFFSET, SUB_THREE, rnd(), ABORT_NO_SUB, 32'h0);
    acc(1'b0, 16'h5000, SUB_COUNT, 32'h0, ABORT_NO_OBJ, 32'h0);
    acc(1'b1, IDX_DIVISOR, SUB_ONE, 32'h0000_0000, ABORT_RANGE, 32'h0, 1'b1);
    acc(1'b1, IDX_DIVISOR, SUB_TWO, 32'h0000_0000, ABORT_RANGE, 32'h0, 1'b1);
    rd(IDX_DIVISOR, SUB_ONE, DIVISOR_PRESET);
    rd(IDX_DIVISOR, SUB_TWO, DIVISOR_PRESET);
    i_master.release_bus();
    $display("test refusals done");
    // Scaling: first pass on presets, then random signed settings
    o1 = 0;
    o2 = 0;
    d1 = 1;
    d2 = 1;
    for (int k = 0; k < 6; k++) begin
      if (k > 0) begin
        t = rnd();
        o1 = {{20{t[11]}}, t[11:0]};
        t = rnd();
        o2 = {{20{t[11]}}, t[11:0]};
        t = rnd();
        d1 = {{24{t[7]}}, t[7:0]};
        t = rnd();
        d2 = {{24{t[7]}}, t[7:0]};
        if (d1 == 0) d1 = 1;
        if (d2 == 0) d2 = -1;
        acc(1'b1, IDX_OFFSET, SUB_ONE, o1, ABORT_NONE, 32'h0);
        acc(1'b1, IDX_OFFSET, SUB_TWO, o2, ABORT_NONE, 32'h0);
        acc(1'b1, IDX_DIVISOR, SUB_ONE, d1, ABORT_NONE, 32'h0);
        acc(1'b1, IDX_DIVISOR, SUB_TWO, d2, ABORT_NONE, 32'h0);
        rd(IDX_DIVISOR, SUB_TWO, d2);
        i_master.release_bus();
      end
      @(negedge sys_clk);
      t = rnd();
      r1 = {{16{t[15]}}, t[15:0]};
      t = rnd();
      r2 = {{16{t[15]}}, t[15:0]};
      raw_in1 = r1;
      raw_in2 = r2;
      raw_valid = 1'b1;
      @(negedge sys_clk);
      raw_valid = 1'b0;
      repeat (34) @(posedge sys_clk);
      @(negedge sys_clk);
      q = (r1 + o1) / d1;
      check("scaled input 1", scaled_in1, q);
      repeat (33) @(posedge sys_clk);
      @(negedge sys_clk);
      q = (r2 + o2) / d2;
      check("scaled input 2", scaled_in2, q);
    end
    $display("test scaling done");
    // Every reaction code, including a reserved one
    foreach (codes[i]) begin
      acc(1'b1, IDX_FE_REACT, SUB_COUNT, {16'h0, codes[i]}, ABORT_NONE, 32'h0);
      rd(IDX_FE_REACT, SUB_COUNT, {{16{codes[i][15]}}, codes[i]});
      i_master.release_bus();
      following_error = 1'b1;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      check("reaction", {28'h0, fe_action}, {28'h0, acts[i]});
      following_error = 1'b0;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      check("reaction idle", {28'h0, fe_action}, 32'h0000_0000);
    end
    $display("test reactions done");
    // Configuration word keeps its reserved bit clear
    acc(1'b1, IDX_HW_CONFIG, SUB_ONE, 32'hFFFF_FFFF, ABORT_NONE, 32'h0);
    rd(IDX_HW_CONFIG, SUB_ONE, 32'hFFFF_FFFE);
    i_master.release_bus();
    @(negedge sys_clk);
    check("config port", hw_config, 32'hFFFF_FFFE);
    $display("test configuration done");
    // Reset in mid-run must bring the configuration, second divisor and reaction presets back
    arst_n = 1'b0;
    @(negedge sys_clk);
    arst_n = 1'b1;
    check("config after reset", hw_config, HW_CONFIG_PRESET);
    rd(IDX_DIVISOR, SUB_TWO, DIVISOR_PRESET);
    rd(IDX_FE_REACT, SUB_COUNT, 32'hFFFF_FFFF);
    i_master.release_bus();
    @(negedge sys_clk);
    check("answers left", exp_q.size(), 32'h0000_0000);
    $display("test reset done");
    wrap_up();
  end
endmodule // asio_object_bank_bench
`default_nettype wire

// ==== asio_pkg.sv ====
// Package for the analog scaling and information object bank
package asio_pkg;

  // Object indices
  localparam logic [15:0] IDX_OFFSET    = 16'h3321;
  localparam logic [15:0] IDX_DIVISOR   = 16'h3322;
  localparam logic [15:0] IDX_FE_REACT  = 16'h3700;
  localparam logic [15:0] IDX_HW_INFO   = 16'h4012;
  localparam logic [15:0] IDX_HW_CONFIG = 16'h4013;
  localparam logic [15:0] IDX_OP_COND   = 16'h4014;
  localparam logic [15:0] IDX_SERIAL    = 16'h4040;
  localparam logic [15:0] IDX_DEVICE_ID = 16'h4041;

  // Subindices
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_ONE   = 8'h01;
  localparam logic [7:0] SUB_TWO   = 8'h02;
  localparam logic [7:0] SUB_THREE = 8'h03;

  // Count entries and presets
  localparam logic [31:0] NUM_ANALOG_IN    = 32'h0000_0002;
  localparam logic [31:0] NUM_HW_INFO      = 32'h0000_0001;
  localparam logic [31:0] NUM_HW_CONFIG    = 32'h0000_0001;
  localparam logic [31:0] NUM_OP_COND      = 32'h0000_0003;
  localparam logic [31:0] OFFSET_PRESET    = 32'h0000_0000;
  localparam logic [31:0] DIVISOR_PRESET   = 32'h0000_0001;
  localparam logic [15:0] FE_REACT_PRESET  = 16'hFFFF;
  localparam logic [31:0] HW_CONFIG_PRESET = 32'h0000_0000;
  localparam logic [31:0] HW_CONFIG_MASK   = 32'hFFFF_FFFE; // bit 0 reserved
  localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;

  // Following error reaction codes
  localparam logic [15:0] FE_NONE      = 16'hFFFF;
  localparam logic [15:0] FE_IMMEDIATE = 16'h0000;
  localparam logic [15:0] FE_SLOW_RAMP = 16'h0001;
  localparam logic [15:0] FE_QUICK     = 16'h0002;

  // Divider timing: one quotient bit per clock
  localparam int DIV_STEPS = 32;

  // Abort codes
  localparam logic [31:0] ABORT_NONE     = 32'h0000_0000;
  localparam logic [31:0] ABORT_NO_OBJ   = 32'h0602_0000;
  localparam logic [31:0] ABORT_NO_SUB   = 32'h0609_0011;
  localparam logic [31:0] ABORT_READONLY = 32'h0601_0002;
  localparam logic [31:0] ABORT_RANGE    = 32'h0609_0030;

  // Object access request from the fieldbus side
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
    logic [7:0]  subindex;
    logic [31:0] wdata;
  } asio_req_t;

  // Answer to an object access
  typedef struct packed {
    logic        valid;
    logic        abort;
    logic [31:0] abort_code;
    logic [31:0] rdata;
  } asio_rsp_t;

  // Following error action, one-hot
  typedef struct packed {
    logic none;
    logic immediate;
    logic slow_ramp;
    logic quick_ramp;
  } asio_fe_action_t;

endpackage : asio_pkg
